// File: src/arts_pkg.sv
package arts_pkg;
  // ----------
  // Register indices; the byte address is four times the index
  // ----------
  localparam logic [7:0] ADDR_IDX_MASK_LO  = 8'he0;
  localparam logic [7:0] ADDR_IDX_SCR_B    = 8'he1;
  localparam logic [7:0] ADDR_IDX_SCR_C    = 8'he2;
  localparam logic [7:0] ADDR_IDX_PINS     = 8'he3;
  localparam logic [7:0] ADDR_IDX_SCR_A    = 8'he8;
  localparam logic [7:0] ADDR_IDX_RLD_HI   = 8'he9;
  localparam logic [7:0] ADDR_IDX_RLD_LO   = 8'hea;
  localparam logic [7:0] ADDR_IDX_CAP_HI   = 8'heb;
  localparam logic [7:0] ADDR_IDX_CAP_LO   = 8'hec;
  localparam logic [7:0] ADDR_IDX_CMP_HI   = 8'hed;
  localparam logic [7:0] ADDR_IDX_CMP_LO   = 8'hee;
  localparam logic [7:0] ADDR_IDX_MASK_HI  = 8'hef;
  localparam logic [7:0] ADDR_IDX_CNT_HI   = 8'hf0;
  localparam logic [7:0] ADDR_IDX_CNT_LO   = 8'hf1;

  // ----------
  // Field positions
  // ----------
  localparam int A_PSC_HI = 7;
  localparam int A_PSC_LO = 6;
  localparam int A_RELOAD = 5;
  localparam int A_RUN    = 4;
  localparam int A_OVFIE  = 3;
  localparam int A_OVFF   = 2;
  localparam int A_OVERFLOW_OUTPUT_MODE  = 1;
  localparam int B_AERR   = 6;
  localparam int B_BERR   = 5;
  localparam int B_AIE    = 4;
  localparam int B_AFLG   = 3;
  localparam int B_APOL   = 2;
  localparam int B_RS_HI  = 1;
  localparam int B_RS_LO  = 0;
  localparam int C_BPOL   = 7;
  localparam int C_BIE    = 6;
  localparam int C_BFLG   = 5;
  localparam int C_CMPIE  = 4;
  localparam int C_CMPF   = 3;
  localparam int C_ZIE    = 2;
  localparam int C_ZF     = 1;
  localparam int C_PULSE_OUTPUT_MODE  = 0;
  localparam int P_OPOL   = 3;
  localparam int P_OEN    = 2;
  localparam int P_PPOL   = 1;
  localparam int P_PEN    = 0;

  // Writable masks (reserved bits read as zero)
  localparam logic [7:0] SCR_A_MASK = 8'hfe;
  localparam logic [7:0] SCR_B_MASK = 8'h7f;
  localparam logic [7:0] PINS_MASK  = 8'h0f;
  // Hardware-set bits: a written one keeps, a zero clears
  localparam logic [7:0] SCR_A_FLAGS = 8'h04;
  localparam logic [7:0] SCR_B_FLAGS = 8'h68;
  localparam logic [7:0] SCR_C_FLAGS = 8'h2a;

  // ----------
  // Encodings and reset values
  // ----------
  localparam logic [1:0] PSC_OFF = 2'h0;
  localparam logic [1:0] PSC_1   = 2'h1;
  localparam logic [1:0] PSC_4   = 2'h2;
  localparam logic [1:0] RS_RUN  = 2'h0;
  localparam logic [1:0] RS_A    = 2'h1;
  localparam logic [1:0] RS_B    = 2'h2;
  localparam logic [3:0] DIV1_TC = 4'h0;
  localparam logic [3:0] DIV4_TC = 4'h3;
  localparam logic [3:0] DIV16_TC = 4'hf;
  localparam logic [7:0]  RST8   = 8'h00;
  localparam logic [15:0] RST16  = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : arts_pkg

// File: src/arts_timer.sv
`timescale 1ns/1ns
// Overview of operation
// R01: Prescaler code: stop, divide 1, 4, 16
// R02: Prescaler off after reset; software zeroes first
// R03: Software sets prescaler before starting counter
// R04: Reload bit picks reload or capture target
// R05: Run bit low clears, holds counter, inputs
// R06: Overflow interrupt only when its enable set
// R07: Event flags set by hardware only
// R08: Overflow pin set mode or toggle mode
// R09: Input A error flag, blocks further events
// R10: Input B error flag, blocks further events
// R11: Error flags only cleared by software
// R12: Per-source enables mask interrupt sources
// R13: Polarity bit selects falling or rising edge
// R14: Reload source code: run, A, B, none
// R15: Input B flag after first capture
// R16: Masked compare sets match flag
// R17: Masked zero flag, not while held cleared
// R18: Pulse pin set/reset or toggle mode
// R19: Overflow pin polarity sets rest level
// R20: Overflow pin disabled rests at polarity
// R21: Pulse pin polarity inverts all levels
// R22: Pulse pin disabled rests at polarity
// R23: High byte latched, applied on low write
// R24: Interrupt is OR of flag-and-enable terms
// R25: Write zero clears flag, one keeps
module arts_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_input_a,
  input  wire logic        capture_input_b,
  output logic             overflow_output_pin,
  output logic             pulse_output_pin,
  output logic             timer_irq
);

  // ----------
  // Registers
  // ----------
  logic [7:0]  scr_a_r, scr_b_r, scr_c_r, pins_r, hi_latch_r;
  logic [15:0] reload_capture_value_r, capture_value_r, compare_r, mask_r, down_counter_r;
  logic [3:0]  pre_cnt_r;
  logic [1:0]  a_sync_r, b_sync_r;
  logic        a_prev_r, b_prev_r, run_prev_r, ovf_state_r, pwm_state_r;
  // ----------
  // Bus decode
  // ----------
  logic       wr, mapped;
  logic [7:0] idx, wd;
  // Unmapped writes die here, so no strobe below repeats the check
  assign wr  = psel & penable & pwrite & mapped;
  assign idx = paddr[9:2];
  assign wd  = pwdata[7:0];
  assign mapped = (paddr[1:0] == 2'h0) && ((idx >= arts_pkg::ADDR_IDX_MASK_LO && idx <= arts_pkg::ADDR_IDX_PINS) ||
                  (idx >= arts_pkg::ADDR_IDX_SCR_A && idx <= arts_pkg::ADDR_IDX_CNT_LO)) && (paddr[11:10] == 2'h0);

  // Byte-wise write strobes
  logic w_a, w_b, w_c, w_p, w_rh, w_rl, w_ch, w_cl, w_mh, w_ml;
  assign w_a  = wr && idx == arts_pkg::ADDR_IDX_SCR_A;
  assign w_b  = wr && idx == arts_pkg::ADDR_IDX_SCR_B;
  assign w_c  = wr && idx == arts_pkg::ADDR_IDX_SCR_C;
  assign w_p  = wr && idx == arts_pkg::ADDR_IDX_PINS;
  assign w_rh = wr && idx == arts_pkg::ADDR_IDX_RLD_HI;
  assign w_rl = wr && idx == arts_pkg::ADDR_IDX_RLD_LO;
  assign w_ch = wr && idx == arts_pkg::ADDR_IDX_CMP_HI;
  assign w_cl = wr && idx == arts_pkg::ADDR_IDX_CMP_LO;
  assign w_mh = wr && idx == arts_pkg::ADDR_IDX_MASK_HI;
  assign w_ml = wr && idx == arts_pkg::ADDR_IDX_MASK_LO;
  // ----------
  // Control fields
  // ----------
  logic [1:0] psc;
  logic [1:0] rsel;
  logic       reload_en;
  logic       run;
  assign psc       = {scr_a_r[arts_pkg::A_PSC_HI], scr_a_r[arts_pkg::A_PSC_LO]};
  assign rsel      = {scr_b_r[arts_pkg::B_RS_HI], scr_b_r[arts_pkg::B_RS_LO]};
  assign reload_en = scr_a_r[arts_pkg::A_RELOAD];
  assign run       = scr_a_r[arts_pkg::A_RUN];
  // ----------
  // Capture inputs: two-stage synchronisers, then edge detect
  // ----------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_sync_r <= 2'h0;
      b_sync_r <= 2'h0;
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
    end else begin
      a_sync_r <= {a_sync_r[0], capture_input_a};
      b_sync_r <= {b_sync_r[0], capture_input_b};
      a_prev_r <= a_sync_r[1];
      b_prev_r <= b_sync_r[1];
    end
  end

  // Edges count once run has stood a cycle: the stale edge after reset cannot fire
  logic a_edge, b_edge, a_evt, b_evt;
  assign a_edge = scr_b_r[arts_pkg::B_APOL] ? (a_sync_r[1] & ~a_prev_r) : (~a_sync_r[1] & a_prev_r); // R13
  assign b_edge = scr_c_r[arts_pkg::C_BPOL] ? (b_sync_r[1] & ~b_prev_r) : (~b_sync_r[1] & b_prev_r); // R13
  assign a_evt  = run & run_prev_r & a_edge & ~scr_b_r[arts_pkg::B_AERR]; // R05 R09
  assign b_evt  = run & run_prev_r & b_edge & ~scr_b_r[arts_pkg::B_BERR]; // R05 R10

  // Capture B only with its flag clear; A captures only in capture mode
  logic b_cap, a_cap;
  assign b_cap = b_evt & ~scr_c_r[arts_pkg::C_BFLG];
  assign a_cap = a_evt & ~scr_b_r[arts_pkg::B_AFLG] & ~reload_en; // R04
  // ----------
  // Prescaler tick
  // ----------
  logic [3:0] tc;
  always_comb begin
    unique case (psc) // R01
      arts_pkg::PSC_OFF: tc = arts_pkg::DIV1_TC;
      arts_pkg::PSC_1:   tc = arts_pkg::DIV1_TC;
      arts_pkg::PSC_4:   tc = arts_pkg::DIV4_TC;
      default:           tc = arts_pkg::DIV16_TC;
    endcase
  end
  logic tick;
  assign tick = run && psc != arts_pkg::PSC_OFF && pre_cnt_r == tc; // R01

  // Prescaler stops and clears when off or while counter is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 4'h0;
    end else if (!run || psc == arts_pkg::PSC_OFF || tick) begin
      pre_cnt_r <= 4'h0; // R01 R02
    end else begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
    end
  end
  // ----------
  // Down counter with reload triggers
  // ----------
  logic start_evt, reload_evt, ovf_evt;
  assign start_evt  = run & ~run_prev_r;
  assign ovf_evt    = tick && down_counter_r == arts_pkg::ZERO16;
  always_comb begin
    reload_evt = 1'b0;
    if (reload_en) begin
      unique case (rsel) // R14
        arts_pkg::RS_RUN: reload_evt = start_evt | ovf_evt;
        arts_pkg::RS_A:   reload_evt = (run & a_edge) | ovf_evt;
        arts_pkg::RS_B:   reload_evt = (run & b_edge) | ovf_evt;
        default:          reload_evt = 1'b0;
      endcase
    end
  end

  // Capture sees the old count, so a coincident reload comes after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_counter_r <= arts_pkg::RST16;
    end else if (!run) begin
      down_counter_r <= arts_pkg::ZERO16; // R05
    end else if (reload_evt) begin
      down_counter_r <= reload_capture_value_r; // R04
    end else if (tick) begin
      down_counter_r <= down_counter_r - 16'h0001; // wraps to ffff when free running
    end
  end
  // ----------
  // Masked compare and masked zero
  // ----------
  logic cmp_hit, zero_hit;
  assign cmp_hit  = run && ((mask_r & down_counter_r) == (mask_r & compare_r)); // R16
  assign zero_hit = run && ((mask_r & down_counter_r) == arts_pkg::ZERO16); // R17
  // ----------
  // 16-bit registers with shared high-byte latch
  // ----------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_latch_r <= arts_pkg::RST8;
    end else if (w_rh || w_ch || w_mh) begin
      hi_latch_r <= wd; // R23
    end
  end
  // Reload/capture: software write only in reload mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_capture_value_r <= arts_pkg::RST16;
    end else if (a_cap) begin
      reload_capture_value_r <= down_counter_r; // R04
    end else if (w_rl && reload_en) begin
      reload_capture_value_r <= {hi_latch_r, wd}; // R23
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_value_r <= arts_pkg::RST16;
    end else if (b_cap) begin
      capture_value_r <= down_counter_r; // R15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_r <= arts_pkg::RST16;
      mask_r    <= arts_pkg::RST16;
    end else begin
      if (w_cl) begin
        compare_r <= {hi_latch_r, wd}; // R23
      end
      if (w_ml) begin
        mask_r <= {hi_latch_r, wd}; // R23
      end
    end
  end
  // ----------
  // Control/status registers; hardware set wins over software clear
  // ----------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_a_r <= arts_pkg::RST8; // R02
    end else begin
      if (w_a) begin
        scr_a_r <= wd & arts_pkg::SCR_A_MASK & (~arts_pkg::SCR_A_FLAGS | scr_a_r); // R25 R07
      end
      if (ovf_evt) begin
        scr_a_r[arts_pkg::A_OVFF] <= 1'b1; // R07
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_b_r <= arts_pkg::RST8;
    end else begin
      if (w_b) begin
        scr_b_r <= wd & arts_pkg::SCR_B_MASK & (~arts_pkg::SCR_B_FLAGS | scr_b_r); // R07 R11 R25
      end
      if (a_evt && scr_b_r[arts_pkg::B_AFLG]) begin
        scr_b_r[arts_pkg::B_AERR] <= 1'b1; // R09
      end
      if (a_evt) begin
        scr_b_r[arts_pkg::B_AFLG] <= 1'b1; // R07
      end
      if (b_evt && scr_c_r[arts_pkg::C_BFLG]) begin
        scr_b_r[arts_pkg::B_BERR] <= 1'b1; // R10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_c_r <= arts_pkg::RST8;
    end else begin
      if (w_c) begin
        scr_c_r <= wd & (~arts_pkg::SCR_C_FLAGS | scr_c_r); // R07 R25
      end
      if (b_cap) begin
        scr_c_r[arts_pkg::C_BFLG] <= 1'b1; // R15
      end
      if (cmp_hit) begin
        scr_c_r[arts_pkg::C_CMPF] <= 1'b1; // R16
      end
      if (zero_hit) begin
        scr_c_r[arts_pkg::C_ZF] <= 1'b1; // R17
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r <= arts_pkg::RST8;
    end else if (w_p) begin
      pins_r <= wd & arts_pkg::PINS_MASK;
    end
  end
  // ----------
  // Output pin state; compare and zero events act on the edge of the condition
  // ----------
  logic cmp_prev_r, zero_prev_r;
  logic cmp_rise, zero_rise;
  assign cmp_rise  = cmp_hit & ~cmp_prev_r;
  assign zero_rise = zero_hit & ~zero_prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_prev_r  <= 1'b0;
      zero_prev_r <= 1'b0;
      run_prev_r  <= 1'b0;
    end else begin
      cmp_prev_r  <= cmp_hit;
      zero_prev_r <= zero_hit;
      run_prev_r  <= run;
    end
  end
  // Set mode follows the flag, so clearing the flag releases the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_state_r <= 1'b0;
    end else if (scr_a_r[arts_pkg::A_OVERFLOW_OUTPUT_MODE]) begin
      if (ovf_evt) begin
        ovf_state_r <= ~ovf_state_r; // R08
      end
    end else begin
      ovf_state_r <= ovf_evt | scr_a_r[arts_pkg::A_OVFF]; // R08
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_state_r <= 1'b0;
    end else if (scr_c_r[arts_pkg::C_PULSE_OUTPUT_MODE]) begin
      if (cmp_rise) begin
        pwm_state_r <= ~pwm_state_r; // R18
      end
    end else if (cmp_rise) begin
      pwm_state_r <= 1'b0; // R18
    end else if (zero_rise) begin
      pwm_state_r <= 1'b1; // R18
    end
  end
  // Pins registered; disabled pins rest at their polarity level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_output_pin <= 1'b0;
      pulse_output_pin    <= 1'b0;
    end else begin
      overflow_output_pin <= pins_r[arts_pkg::P_OPOL] ^
                             (pins_r[arts_pkg::P_OEN] & ovf_state_r); // R19 R20
      pulse_output_pin    <= pins_r[arts_pkg::P_PPOL] ^
                             (pins_r[arts_pkg::P_PEN] & pwm_state_r); // R21 R22
    end
  end
  // ----------
  // Interrupt request
  // ----------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (scr_a_r[arts_pkg::A_OVFF] & scr_a_r[arts_pkg::A_OVFIE]) | // R06 R24
                   (scr_b_r[arts_pkg::B_AFLG] & scr_b_r[arts_pkg::B_AIE]) | // R12
                   (scr_c_r[arts_pkg::C_BFLG] & scr_c_r[arts_pkg::C_BIE]) | // R12
                   (scr_c_r[arts_pkg::C_CMPF] & scr_c_r[arts_pkg::C_CMPIE]) | // R12
                   (scr_c_r[arts_pkg::C_ZF] & scr_c_r[arts_pkg::C_ZIE]); // R12
    end
  end
  // ----------
  // APB read path: zero wait states; high reads show live register
  // ----------
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    unique case (idx)
      arts_pkg::ADDR_IDX_MASK_LO: rd = mask_r[7:0];
      arts_pkg::ADDR_IDX_SCR_B:   rd = scr_b_r;
      arts_pkg::ADDR_IDX_SCR_C:   rd = scr_c_r;
      arts_pkg::ADDR_IDX_PINS:    rd = pins_r;
      arts_pkg::ADDR_IDX_SCR_A:   rd = scr_a_r;
      arts_pkg::ADDR_IDX_RLD_HI:  rd = reload_capture_value_r[15:8]; // R23
      arts_pkg::ADDR_IDX_RLD_LO:  rd = reload_capture_value_r[7:0];
      arts_pkg::ADDR_IDX_CAP_HI:  rd = capture_value_r[15:8];
      arts_pkg::ADDR_IDX_CAP_LO:  rd = capture_value_r[7:0];
      arts_pkg::ADDR_IDX_CMP_HI:  rd = compare_r[15:8]; // R23
      arts_pkg::ADDR_IDX_CMP_LO:  rd = compare_r[7:0];
      arts_pkg::ADDR_IDX_MASK_HI: rd = mask_r[15:8]; // R23
      arts_pkg::ADDR_IDX_CNT_HI:  rd = down_counter_r[15:8];
      arts_pkg::ADDR_IDX_CNT_LO:  rd = down_counter_r[7:0];
      default:                    rd = 8'h00;
    endcase
  end
  // Answer registered in setup, so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite & mapped) ? {24'h0, rd} : 32'h0;
    end
  end

endmodule : arts_timer

// File: verif/arts_far_side.sv
`timescale 1ns/1ns
// -------------------------------------------------------
// Capture pulse source on the far side of the pins
// -------------------------------------------------------
module arts_far_side (
  input  wire logic want_a,
  input  wire logic want_b,
  output logic      capture_input_a,
  output logic      capture_input_b
);
  // Levels hold until the bench asks for the next edge, so no glitch reaches the synchronisers
  always_comb begin
    capture_input_a = want_a;
    capture_input_b = want_b;
  end
endmodule : arts_far_side

// File: verif/arts_checker.sv
`timescale 1ns/1ns
module arts_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        capture_input_a,
  input wire logic        capture_input_b,
  input wire logic        overflow_output_pin,
  input wire logic        pulse_output_pin,
  input wire logic        timer_irq
);
  logic [7:0] a_r, b_r, c_r, p_r, lat_r, cmph_r;
  logic [7:0] wi;
  logic [4:0] ens;
  logic       wr_hit, rd_hit, run_off;

  // -------------------------------------------------------
  // Shadow of the control bits software has written
  // -------------------------------------------------------
  assign wi      = paddr[9:2];
  assign wr_hit  = psel && penable && pready && pwrite && !pslverr;
  assign rd_hit  = psel && penable && pready && !pwrite;
  assign run_off = !a_r[4];
  assign ens     = {a_r[3], b_r[4], c_r[6], c_r[4], c_r[2]};

  // Flags are not tracked: hardware owns them; only enables, the run bit, pin controls and the compare high byte matter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {a_r, b_r, c_r, p_r, lat_r, cmph_r} <= '0;
    end else if (wr_hit) begin
      if (wi == arts_pkg::ADDR_IDX_SCR_A) a_r <= pwdata[7:0];
      if (wi == arts_pkg::ADDR_IDX_SCR_B) b_r <= pwdata[7:0];
      if (wi == arts_pkg::ADDR_IDX_SCR_C) c_r <= pwdata[7:0];
      if (wi == arts_pkg::ADDR_IDX_PINS) p_r <= pwdata[7:0];
      if (wi inside {arts_pkg::ADDR_IDX_RLD_HI, arts_pkg::ADDR_IDX_CMP_HI, arts_pkg::ADDR_IDX_MASK_HI}) lat_r <= pwdata[7:0];
      if (wi == arts_pkg::ADDR_IDX_CMP_LO) cmph_r <= lat_r;
    end
  end

  function automatic logic arts_mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && a[11:10] == 2'h0 && (a[9:2] inside
      {[arts_pkg::ADDR_IDX_MASK_LO:arts_pkg::ADDR_IDX_PINS], [arts_pkg::ADDR_IDX_SCR_A:arts_pkg::ADDR_IDX_CNT_LO]});
  endfunction : arts_mapped

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside access");
  unmapped_err_a: assert property (psel && !penable && !arts_mapped(paddr) |=> pslverr)
    else $error("no error for unmapped address");
  ovf_idle_level_a: assert property (!p_r[2] && $stable(p_r) |-> overflow_output_pin == p_r[3])
    else $error("disabled overflow pin not at polarity");
  pulse_idle_level_a: assert property (!p_r[0] && $stable(p_r) |-> pulse_output_pin == p_r[1])
    else $error("disabled pulse pin not at polarity");
  irq_masked_a: assert property (ens == 5'h0 && $stable(ens) |-> !timer_irq)
    else $error("interrupt with every source masked");
  irq_raise_a: assert property (rd_hit && wi == arts_pkg::ADDR_IDX_SCR_C && prdata[5] && c_r[6]
    && $stable(c_r) |-> ##[0:2] timer_irq)
    else $error("interrupt missing for enabled flag");
  counter_clear_a: assert property (rd_hit && wi == arts_pkg::ADDR_IDX_CNT_LO && run_off
    && $past(run_off) && $past(run_off, 2) |-> prdata == 32'h0)
    else $error("counter not cleared while stopped");
  hi_live_a: assert property (rd_hit && wi == arts_pkg::ADDR_IDX_CMP_HI |-> prdata[7:0] == cmph_r)
    else $error("high byte read not the live value");

  irq_seen_c: cover property (timer_irq);
  err_seen_c: cover property (pslverr);
  ovf_active_c: cover property (p_r[2] && overflow_output_pin != p_r[3]);
endmodule : arts_checker

bind arts_timer arts_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_input_a(capture_input_a), .capture_input_b(capture_input_b),
  .overflow_output_pin(overflow_output_pin), .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq));

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        cap_a, cap_b, want_a, want_b, ovf_pin, pulse_pin, irq;
  int          fails, num_checks, cyc;
  logic [7:0]  q, q2;

  // -------------------------------------------------------
  // Clock, design, far side and hang guard
  // -------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  arts_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_a(cap_a), .capture_input_b(cap_b), .overflow_output_pin(ovf_pin),
    .pulse_output_pin(pulse_pin), .timer_irq(irq));
  arts_far_side u_far (.want_a(want_a), .want_b(want_b), .capture_input_a(cap_a), .capture_input_b(cap_b));
  // The whole run needs about 1000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  // -------------------------------------------------------
  // Bus cycles and comparison
  // -------------------------------------------------------
  // Idle edge after each transfer so psel is never assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r, output logic e);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 2'h0, idx, 2'h0, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No cycle count assumed; only the hang guard ends a stuck wait
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata[7:0];
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    xfer(1'b1, idx, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] r);
    logic e;
    xfer(1'b0, idx, 8'h00, r, e);
  endtask : rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic edge_to(input logic ch, input logic lvl);
    if (ch) want_b <= lvl;
    else want_a <= lvl;
    repeat (8) @(posedge pclk);
  endtask : edge_to

  // -------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------
  // Reset value, an unmapped slot, high byte latch
  task automatic t_regs;
    logic e;
    rd(arts_pkg::ADDR_IDX_SCR_A, q);
    chk(q, 8'h00, "control after reset");
    xfer(1'b0, 8'he4, 8'h00, q, e);
    chk({7'h0, e}, 8'h01, "unmapped slot");
    wr(arts_pkg::ADDR_IDX_CMP_HI, 8'h55);
    wr(arts_pkg::ADDR_IDX_CMP_LO, 8'h00);
    wr(arts_pkg::ADDR_IDX_CMP_HI, 8'haa);
    rd(arts_pkg::ADDR_IDX_CMP_HI, q);
    chk(q, 8'h55, "high byte before low write");
    wr(arts_pkg::ADDR_IDX_CMP_LO, 8'h00);
    rd(arts_pkg::ADDR_IDX_CMP_HI, q);
    chk(q, 8'haa, "high byte after low write");
  endtask : t_regs

  // Each prescaler code over a 67 cycle gap between two samples
  task automatic t_rate;
    int ex, dv, tol;
    for (int c = 0; c < 4; c++) begin
      wr(arts_pkg::ADDR_IDX_SCR_A, 8'h00);
      wr(arts_pkg::ADDR_IDX_SCR_A, 8'(c << 6));
      wr(arts_pkg::ADDR_IDX_SCR_A, 8'(c << 6) | 8'h10);
      rd(arts_pkg::ADDR_IDX_CNT_LO, q);
      repeat (64) @(posedge pclk);
      rd(arts_pkg::ADDR_IDX_CNT_LO, q2);
      ex = (c == 0) ? 0 : 67 >> (2 * c - 2);
      tol = (c == 0) ? 0 : 1;
      dv = int'(8'(q - q2));
      chk(8'(dv >= ex - tol && dv <= ex + tol), 8'h01, "count rate");
    end
    wr(arts_pkg::ADDR_IDX_SCR_A, 8'h40);
    rd(arts_pkg::ADDR_IDX_CNT_HI, q);
    chk(q, 8'h00, "stopped counter high");
  endtask : t_rate

  // One capture channel at one polarity: flag, masking, error, clearing
  task automatic t_capture(input logic ch, input logic pol);
    logic [7:0] pr, v, fm, im, em;
    pr = ch ? arts_pkg::ADDR_IDX_SCR_C : arts_pkg::ADDR_IDX_SCR_B;
    v = ch ? {pol, 7'h00} : {5'h00, pol, 2'h0};
    fm = ch ? 8'h20 : 8'h08;
    im = ch ? 8'h40 : 8'h10;
    em = ch ? 8'h20 : 8'h40;
    edge_to(ch, ~pol);
    wr(arts_pkg::ADDR_IDX_SCR_B, ch ? 8'h00 : v);
    wr(arts_pkg::ADDR_IDX_SCR_C, ch ? v : 8'h00);
    edge_to(ch, pol);
    rd(pr, q);
    chk(q & fm, fm, "event flag");
    chk({7'h0, irq}, 8'h00, "masked source");
    wr(pr, v | im | fm);
    rd(pr, q);
    chk(q & fm, fm, "flag kept by a one");
    chk({7'h0, irq}, 8'h01, "enabled source");
    edge_to(ch, ~pol);
    edge_to(ch, pol);
    rd(arts_pkg::ADDR_IDX_SCR_B, q);
    chk(q & em, em, "repeat event error");
    wr(arts_pkg::ADDR_IDX_SCR_B, 8'h00);
    wr(arts_pkg::ADDR_IDX_SCR_C, 8'h00);
    wr(pr, v | fm | (ch ? 8'h00 : em));
    rd(pr, q);
    chk(q & (fm | em), 8'h00, "flags not set by software");
  endtask : t_capture

  // Overflow pin in set mode, cleared with its flag, then toggle mode
  task automatic t_ovf;
    int   n;
    logic pv;
    wr(arts_pkg::ADDR_IDX_SCR_A, 8'h20);
    wr(arts_pkg::ADDR_IDX_PINS, 8'h04);
    wr(arts_pkg::ADDR_IDX_RLD_HI, 8'h00);
    wr(arts_pkg::ADDR_IDX_RLD_LO, 8'h3f);
    wr(arts_pkg::ADDR_IDX_SCR_A, 8'h60);
    wr(arts_pkg::ADDR_IDX_SCR_A, 8'h70);
    repeat (100) @(posedge pclk);
    chk({7'h0, ovf_pin}, 8'h01, "set on overflow");
    wr(arts_pkg::ADDR_IDX_SCR_A, 8'h30);
    repeat (2) @(posedge pclk);
    chk({7'h0, ovf_pin}, 8'h00, "released with flag");
    wr(arts_pkg::ADDR_IDX_PINS, 8'h0e);
    repeat (2) @(posedge pclk);
    chk({7'h0, ovf_pin}, 8'h01, "inverted rest level");
    chk({7'h0, pulse_pin}, 8'h01, "disabled pulse pin level");
    wr(arts_pkg::ADDR_IDX_SCR_A, 8'h72);
    n = 0;
    pv = ovf_pin;
    repeat (256) begin
      @(posedge pclk);
      if (ovf_pin !== pv) n++;
      pv = ovf_pin;
    end
    chk(8'(n), 8'h04, "toggle per overflow");
  endtask : t_ovf

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // Main sequence; software order keeps the prescaler off while changing it, except the stop write after the rate loop (code 3 to 1)
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {want_a, want_b} = 2'b11;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_rate();
    wr(arts_pkg::ADDR_IDX_SCR_A, 8'h50);
    for (int i = 0; i < 4; i++) t_capture(i[1], i[0]);
    t_ovf();
    conclude();
  end
endmodule : tb_top
